//--- hdl/dsc_defines.svh
// register offsets, reset values, ranges and timing of the setpoint conditioner
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH
`define DSC_OFF_CTRL      8'h00
`define DSC_OFF_SKIP_IN   8'h04
`define DSC_OFF_RISE_CAP  8'h08
`define DSC_OFF_FALL_CAP  8'h0C
`define DSC_OFF_MOT_CAP   8'h10
`define DSC_OFF_BRK_CAP   8'h14
`define DSC_OFF_OUT_PCT   8'h18
`define DSC_OFF_OUT_HZ    8'h1C
`define DSC_OFF_IN_HZ     8'h20
`define DSC_OFF_SP_HZ     8'h24
`define DSC_OFF_BAND0     8'h40
`define DSC_BAND_STRIDE   8'h08
`define DSC_BAND_CENTRE   8'h04
`define DSC_CTRL_SLEW_BIT 0
`define DSC_CTRL_SLIP_BIT 1
`define DSC_PCT_MAX       16'sh7530
`define DSC_PCT_FULL      32'sh0000_2710
`define DSC_HZ_MAX        16'h1388
`define DSC_RATE_MIN      16'h000A
`define DSC_RATE_MAX      16'h2EE0
`define DSC_RATE_RST      16'h1388
`define DSC_TRIM_MAX      16'h1770
`define DSC_TRIM_RST      16'h05DC
`define DSC_FRAC          40'sh00_000F_4240
`define DSC_CLK_PERIOD_NS 40
`define DSC_NS_PER_US     1000
`define DSC_RPM_PER_HZ    32'sh0000_003C
`endif

//--- hdl/dsc_pkg.sv
// types shared by the setpoint conditioner modules
package dsc_pkg;
   typedef enum logic [0:0] {BUS_IDLE, BUS_ACCESS} dsc_bus_state_type;
   typedef logic [15:0] dsc_band_type [4];
endpackage : dsc_pkg

//--- hdl/dsc_skip.sv
// skip-band stage: moves the setpoint magnitude out of four resonance bands
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defines.svh"
module dsc_skip
   import dsc_pkg::*;
#(
   parameter int BANDS = 4
)(
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic ce_in,
   dsc_skip_if.stage sk
);
   if (BANDS != 4)
   begin : g_bad_bands
      $error("dsc_skip serves exactly four bands");
   end

   logic signed [17:0] mag [BANDS+1];
   logic signed [15:0] out_ff;

   assign mag[0] = sk.in_hz[15] ? -18'(sk.in_hz) : 18'(sk.in_hz);

   genvar i;
   generate
      for (i = 0; i < BANDS; i++)
      begin : g_band
         logic signed [17:0] w;
         logic signed [17:0] lo;
         logic signed [17:0] hi;
         logic               on;
         // zero width borrows the first band's width
         assign w  = (sk.width[i] != 16'h0000) ? 18'(sk.width[i]) : 18'(sk.width[0]);
         assign lo = 18'(sk.centre[i]) - (w >>> 1);
         assign hi = 18'(sk.centre[i]) + (w >>> 1);
         assign on = (sk.centre[i] != 16'h0000);
         // inside the band the nearer edge wins, or the upper edge if the lower is not above zero, so the output jumps across
         assign mag[i+1] = (on && mag[i] > lo && mag[i] < hi) ?
                           (((mag[i] - lo) <= (hi - mag[i]) && lo > 18'sh0_0000) ? lo : hi) : mag[i];
      end
   endgenerate

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         out_ff <= 16'sh0000;
      else if (ce_in)
         out_ff <= sk.in_hz[15] ? -16'(mag[BANDS]) : 16'(mag[BANDS]);
   end

   assign sk.out_hz = out_ff;

   property p_sign_kept;
      @(posedge clk_in) disable iff (reset_in)
      ce_in && sk.in_hz < 16'sh0000 |=> out_ff <= 16'sh0000;
   endproperty
   a_sign_kept: assert property (p_sign_kept) else $error("skip output sign flipped");

   property p_no_band_off;
      @(posedge clk_in) disable iff (reset_in)
      ce_in && sk.centre[0] == 16'h0000 && sk.centre[1] == 16'h0000 &&
      sk.centre[2] == 16'h0000 && sk.centre[3] == 16'h0000 |=> out_ff == $past(sk.in_hz);
   endproperty
   a_no_band_off: assert property (p_no_band_off) else $error("disabled bands moved setpoint");

   property p_not_inside0;
      @(posedge clk_in) disable iff (reset_in)
      ce_in && sk.centre[0] != 16'h0000 && sk.width[0] > 16'h0002 && sk.centre[0] > sk.width[0] &&
      mag[0] == 18'(sk.centre[0]) |=> out_ff != $past(sk.in_hz);
   endproperty
   a_not_inside0: assert property (p_not_inside0) else $error("output left at band centre");
endmodule : dsc_skip
`default_nettype wire

//--- hdl/dsc_skip_if.sv
// carrier between the conditioner core and its skip-band stage
`timescale 1ns/1ns
`default_nettype none
interface dsc_skip_if;
   import dsc_pkg::*;
   logic signed [15:0] in_hz;
   dsc_band_type       width;
   dsc_band_type       centre;
   logic signed [15:0] out_hz;
   modport core  (output in_hz, output width, output centre, input out_hz);
   modport stage (input in_hz, input width, input centre, output out_hz);
endinterface : dsc_skip_if
`default_nettype wire

//--- hdl/dsc_top.sv
// setpoint conditioner: skip bands, rise/fall rate limit, brake hold, slip trim clamp, APB registers
//
// Overview of operation
// - four skip bands, centre and width each
// - output never dwells inside an enabled band
// - bands apply alike to reverse demand
// - zero centre disables that band
// - zero width takes the first band's width
// - skip input signed percent, +-300, reset zero
// - widths and centres 0 to 500.0 Hz
// - read back output percent, output and input hertz
// - rate limiter off passes setpoint; resets on
// - rising magnitude limited by rise cap
// - falling magnitude limited by fall cap
// - brake hold freezes the limited setpoint; the code ignores the hold while the rate limiter is off
// - slip trim only when slip enabled
// - motoring trim clamped to motoring cap
// - regenerating trim clamped to braking cap
// - slip trim added to the demand frequency, either sign
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defines.svh"
module dsc_top
   import dsc_pkg::*;
#(
   parameter int TICK_US     = 1000,
   parameter int MAX_HZ_X10  = 500,
   parameter int POLE_PAIRS  = 2
)(
   // clock, reset, enable
   input  wire logic               CLK_IN,
   input  wire logic               RESET_IN,
   input  wire logic               CE_IN,
   // apb slave
   input  wire logic               PSEL_IN,
   input  wire logic               PENABLE_IN,
   input  wire logic               PWRITE_IN,
   input  wire logic [7:0]         PADDR_IN,
   input  wire logic [31:0]        PWDATA_IN,
   output logic      [31:0]        PRDATA_OUT,
   output logic                    PREADY_OUT,
   output logic                    PSLVERR_OUT,
   // drive side
   input  wire logic               BRAKE_HOLD_IN,
   input  wire logic               REGEN_IN,
   input  wire logic signed [15:0] SLIP_RAW_IN,
   output logic signed [15:0]      SETPOINT_OUT,
   output logic signed [15:0]      SLIP_TRIM_OUT,
   output logic signed [15:0]      DEMAND_OUT
);
   localparam int TICK_CYC = TICK_US * `DSC_NS_PER_US / `DSC_CLK_PERIOD_NS;
   if (TICK_CYC < 1 || MAX_HZ_X10 < 1 || MAX_HZ_X10 > 5000 || POLE_PAIRS < 1)
   begin : g_bad_param
      $error("dsc_top parameters out of range");
   end

   dsc_skip_if sk ();

   dsc_bus_state_type  bus_ff;
   logic               slew_en_ff;
   logic               slip_en_ff;
   logic signed [15:0] skip_in_ff;
   logic        [15:0] rise_cap_ff;
   logic        [15:0] fall_cap_ff;
   logic        [15:0] mot_cap_ff;
   logic        [15:0] brk_cap_ff;
   dsc_band_type       width_ff;
   dsc_band_type       centre_ff;
   logic signed [15:0] in_hz_ff;
   logic signed [15:0] out_pct_ff;
   logic signed [39:0] sp_ff;
   logic signed [39:0] nxt_sp;
   logic signed [39:0] target;
   logic signed [39:0] rise_step;
   logic signed [39:0] fall_step;
   logic [31:0]        tick_cnt_ff;
   logic               tick;
   logic               wr;
   logic [31:0]        rd_data;
   logic               rd_ok;
   logic signed [15:0] trim_cap;
   logic signed [15:0] nxt_trim;
   logic [15:0]        wdat16;

   assign wdat16 = PWDATA_IN[15:0];
   assign wr     = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;

   // apb: setup cycle arms a one-cycle ready, so every access has no wait state
   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         bus_ff      <= BUS_IDLE;
         PREADY_OUT  <= 1'b0;
         PRDATA_OUT  <= 32'h0000_0000;
         PSLVERR_OUT <= 1'b0;
      end
      else if (CE_IN)
      begin
         case (bus_ff)
            BUS_IDLE:
            begin
               PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
               PRDATA_OUT  <= (PSEL_IN && !PWRITE_IN) ? rd_data : 32'h0000_0000;
               PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !rd_ok;
               bus_ff      <= (PSEL_IN && !PENABLE_IN) ? BUS_ACCESS : BUS_IDLE;
            end
            BUS_ACCESS:
            begin
               PREADY_OUT  <= 1'b0;
               PSLVERR_OUT <= 1'b0;
               bus_ff      <= BUS_IDLE;
            end
            default:
            begin
               PREADY_OUT <= 1'b0;
               bus_ff     <= BUS_IDLE;
            end
         endcase
      end
   end

   // register writes clip to the documented ranges instead of refusing them
   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         slew_en_ff  <= 1'b1;
         slip_en_ff  <= 1'b0;
         skip_in_ff  <= 16'sh0000;
         rise_cap_ff <= `DSC_RATE_RST;
         fall_cap_ff <= `DSC_RATE_RST;
         mot_cap_ff  <= `DSC_TRIM_RST;
         brk_cap_ff  <= `DSC_TRIM_RST;
      end
      else if (CE_IN && wr)
      begin
         case (PADDR_IN)
            `DSC_OFF_CTRL:
            begin
               slew_en_ff <= PWDATA_IN[`DSC_CTRL_SLEW_BIT];
               slip_en_ff <= PWDATA_IN[`DSC_CTRL_SLIP_BIT];
            end
            `DSC_OFF_SKIP_IN:
               skip_in_ff <= ($signed(wdat16) > `DSC_PCT_MAX) ? `DSC_PCT_MAX :
                             ($signed(wdat16) < -`DSC_PCT_MAX) ? -`DSC_PCT_MAX : $signed(wdat16);
            `DSC_OFF_RISE_CAP:
               rise_cap_ff <= (wdat16 < `DSC_RATE_MIN) ? `DSC_RATE_MIN :
                              (wdat16 > `DSC_RATE_MAX) ? `DSC_RATE_MAX : wdat16;
            `DSC_OFF_FALL_CAP:
               fall_cap_ff <= (wdat16 < `DSC_RATE_MIN) ? `DSC_RATE_MIN :
                              (wdat16 > `DSC_RATE_MAX) ? `DSC_RATE_MAX : wdat16;
            `DSC_OFF_MOT_CAP:
               mot_cap_ff <= (wdat16 > `DSC_TRIM_MAX) ? `DSC_TRIM_MAX : wdat16;
            `DSC_OFF_BRK_CAP:
               brk_cap_ff <= (wdat16 > `DSC_TRIM_MAX) ? `DSC_TRIM_MAX : wdat16;
            default: ;
         endcase
      end
   end

   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_band_reg
         localparam logic [7:0] W_OFF = `DSC_OFF_BAND0 + 8'(b) * `DSC_BAND_STRIDE;
         always_ff @(posedge CLK_IN or posedge RESET_IN)
         begin
            if (RESET_IN)
            begin
               width_ff[b]  <= 16'h0000;
               centre_ff[b] <= 16'h0000;
            end
            else if (CE_IN && wr && PADDR_IN == W_OFF)
               width_ff[b] <= (wdat16 > `DSC_HZ_MAX) ? `DSC_HZ_MAX : wdat16;
            else if (CE_IN && wr && PADDR_IN == W_OFF + `DSC_BAND_CENTRE)
               centre_ff[b] <= (wdat16 > `DSC_HZ_MAX) ? `DSC_HZ_MAX : wdat16;
         end
      end
   endgenerate

   // read mux; bands decoded from address bits
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (PADDR_IN)
         `DSC_OFF_CTRL:     rd_data = {30'h0000_0000, slip_en_ff, slew_en_ff};
         `DSC_OFF_SKIP_IN:  rd_data = 32'(skip_in_ff);
         `DSC_OFF_RISE_CAP: rd_data = {16'h0000, rise_cap_ff};
         `DSC_OFF_FALL_CAP: rd_data = {16'h0000, fall_cap_ff};
         `DSC_OFF_MOT_CAP:  rd_data = {16'h0000, mot_cap_ff};
         `DSC_OFF_BRK_CAP:  rd_data = {16'h0000, brk_cap_ff};
         `DSC_OFF_OUT_PCT:  rd_data = 32'(out_pct_ff);
         `DSC_OFF_OUT_HZ:   rd_data = 32'(sk.out_hz);
         `DSC_OFF_IN_HZ:    rd_data = 32'(in_hz_ff);
         `DSC_OFF_SP_HZ:    rd_data = 32'(SETPOINT_OUT);
         default:
         begin
            if (PADDR_IN >= `DSC_OFF_BAND0 && PADDR_IN[7:5] == 3'h2 && PADDR_IN[1:0] == 2'h0)
               rd_data = {16'h0000, PADDR_IN[2] ? centre_ff[PADDR_IN[4:3]] : width_ff[PADDR_IN[4:3]]};
            else
               rd_ok = 1'b0;
         end
      endcase
   end

   // percent to hertz ahead of the skip stage, and back again for diagnostics
   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         in_hz_ff   <= 16'sh0000;
         out_pct_ff <= 16'sh0000;
      end
      else if (CE_IN)
      begin
         in_hz_ff   <= 16'(32'(skip_in_ff) * MAX_HZ_X10 / `DSC_PCT_FULL);
         out_pct_ff <= 16'(32'(sk.out_hz) * `DSC_PCT_FULL / MAX_HZ_X10);
      end
   end

   assign sk.in_hz  = in_hz_ff;
   assign sk.width  = width_ff;
   assign sk.centre = centre_ff;

   dsc_skip #(.BANDS(4)) u_skip (
      .clk_in   (CLK_IN),
      .reset_in (RESET_IN),
      .ce_in    (CE_IN),
      .sk       (sk.stage)
   );

   // tick prescaler; the limiter moves only on ticks
   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
         tick_cnt_ff <= 32'h0000_0000;
      else if (CE_IN)
         tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
   end
   assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));

   // accumulator keeps sub-count fractions so low caps still move
   assign target    = 40'(sk.out_hz) * `DSC_FRAC;
   assign rise_step = 40'(rise_cap_ff) * 40'(TICK_US);
   assign fall_step = 40'(fall_cap_ff) * 40'(TICK_US);

   always_comb
   begin
      nxt_sp = sp_ff;
      if (!slew_en_ff)
         nxt_sp = target;
      else if (BRAKE_HOLD_IN)
         nxt_sp = sp_ff;
      else if (tick)
      begin
         if (target > sp_ff)
         begin
            if (sp_ff >= 40'sh00_0000_0000)
               nxt_sp = (target - sp_ff > rise_step) ? sp_ff + rise_step : target;
            else
               nxt_sp = (target - sp_ff > fall_step) ? sp_ff + fall_step : target;
         end
         else if (target < sp_ff)
         begin
            if (sp_ff <= 40'sh00_0000_0000)
               nxt_sp = (sp_ff - target > rise_step) ? sp_ff - rise_step : target;
            else
               nxt_sp = (sp_ff - target > fall_step) ? sp_ff - fall_step : target;
         end
      end
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         sp_ff        <= 40'sh00_0000_0000;
         SETPOINT_OUT <= 16'sh0000;
      end
      else if (CE_IN)
      begin
         sp_ff        <= nxt_sp;
         SETPOINT_OUT <= 16'(nxt_sp / `DSC_FRAC);
      end
   end

   // slip trim: clamp chosen by power flow direction
   assign trim_cap = REGEN_IN ? $signed(brk_cap_ff) : $signed(mot_cap_ff);

   always_comb
   begin
      nxt_trim = 16'sh0000;
      if (slip_en_ff)
      begin
         if (SLIP_RAW_IN > trim_cap)
            nxt_trim = trim_cap;
         else if (SLIP_RAW_IN < -trim_cap)
            nxt_trim = -trim_cap;
         else
            nxt_trim = SLIP_RAW_IN;
      end
   end

   always_ff @(posedge CLK_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         SLIP_TRIM_OUT <= 16'sh0000;
         DEMAND_OUT    <= 16'sh0000;
      end
      else if (CE_IN)
      begin
         SLIP_TRIM_OUT <= nxt_trim;
         // rpm trim becomes hertz on top of the limited setpoint
         DEMAND_OUT    <= 16'(32'(SETPOINT_OUT) + 32'(SLIP_TRIM_OUT) * POLE_PAIRS / `DSC_RPM_PER_HZ);
      end
   end

   property p_slip_off;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && !slip_en_ff |=> SLIP_TRIM_OUT == 16'sh0000;
   endproperty
   a_slip_off: assert property (p_slip_off) else $error("trim while slip disabled");
   property p_mot_clamp;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && slip_en_ff && !REGEN_IN && SLIP_RAW_IN > $signed(mot_cap_ff)
      |=> SLIP_TRIM_OUT == $signed($past(mot_cap_ff));
   endproperty
   a_mot_clamp: assert property (p_mot_clamp) else $error("motoring trim not clamped");
   property p_brk_clamp;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && slip_en_ff && REGEN_IN && SLIP_RAW_IN < -$signed(brk_cap_ff)
      |=> SLIP_TRIM_OUT == -$signed($past(brk_cap_ff));
   endproperty
   a_brk_clamp: assert property (p_brk_clamp) else $error("regenerating trim not clamped");
   property p_hold;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && slew_en_ff && BRAKE_HOLD_IN |=> sp_ff == $past(sp_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("setpoint moved during brake hold");
   property p_bypass;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && !slew_en_ff |=> sp_ff == $past(target);
   endproperty
   a_bypass: assert property (p_bypass) else $error("limiter not bypassed");
   property p_rate;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && slew_en_ff |=> (sp_ff - $past(sp_ff) <= $past(rise_step) + $past(fall_step)) &&
                              ($past(sp_ff) - sp_ff <= $past(rise_step) + $past(fall_step));
   endproperty
   a_rate: assert property (p_rate) else $error("setpoint step exceeds caps");
   property p_no_tick_still;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && slew_en_ff && !tick |=> sp_ff == $past(sp_ff);
   endproperty
   a_no_tick_still: assert property (p_no_tick_still) else $error("limiter moved between ticks");
   property p_ready_one;
      @(posedge CLK_IN) disable iff (RESET_IN)
      CE_IN && PSEL_IN && !PENABLE_IN && bus_ff == BUS_IDLE |=> PREADY_OUT ##1 !PREADY_OUT [*2];
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("apb ready not a single access pulse");
endmodule : dsc_top
`default_nettype wire

//--- verif/dsc_far_model.sv
// far-side model: braking hold source and slip estimate feeding the conditioner
`timescale 1ns/1ns
`default_nettype none
module dsc_far_model (
   // clock
   input  wire logic          clk_in,
   // drive side
   output logic               hold_out,
   output logic               regen_out,
   output logic signed [15:0] slip_out
);
   initial
   begin
      hold_out  = 1'b0;
      regen_out = 1'b0;
      slip_out  = 16'sh0000;
   end

   // hold raised for n clocks, then dropped; real holds are short
   task automatic hold_for(input int n);
      @(posedge clk_in);
      hold_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      hold_out <= 1'b0;
   endtask : hold_for

   task automatic load(input logic regen, input logic signed [15:0] slip);
      @(posedge clk_in);
      regen_out <= regen;
      slip_out  <= slip;
   endtask : load
endmodule : dsc_far_model
`default_nettype wire

//--- verif/test_dsc_top.sv
// self-checking bench for the setpoint conditioner
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_dsc_top;
   logic               clk     = 1'b0;
   logic               rst     = 1'b1;
   logic               ce      = 1'b1;
   logic               psel    = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite  = 1'b0;
   logic [7:0]         paddr   = 8'h00;
   logic [31:0]        pwdata  = 32'h0000_0000;
   logic [31:0]        prdata;
   logic [31:0]        rd;
   logic               pready, pslverr, err, hold, regen;
   logic signed [15:0] slip, sp, trim, dem;
   int                 fail_count      = 0;
   int                 samples_checked = 0;

   always #20 clk = ~clk;

   // short tick keeps the limiter visible in a short run
   dsc_top #(.TICK_US(4)) dsc_top_inst (
      .CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .BRAKE_HOLD_IN(hold), .REGEN_IN(regen), .SLIP_RAW_IN(slip),
      .SETPOINT_OUT(sp), .SLIP_TRIM_OUT(trim), .DEMAND_OUT(dem));

   dsc_far_model dsc_far_model_inst (.clk_in(clk), .hold_out(hold), .regen_out(regen), .slip_out(slip));

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request stands until ready is seen at a rising edge; the watchdog ends a hang
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK({err, rd}, {1'b0, e})
   endtask : rdchk

   function automatic logic [7:0] bw(input int i);
      return `DSC_OFF_BAND0 + `DSC_BAND_STRIDE * 8'(i);
   endfunction : bw

   // input in 0.1 Hz; 100 % is 50.0 Hz, so percent units are 20 per step
   task automatic setin(input int h);
      wr(`DSC_OFF_SKIP_IN, h * 20);
      repeat (8) @(posedge clk);
   endtask : setin

   task automatic t_reset;
      rdchk(`DSC_OFF_CTRL, 32'h0000_0001);
      rdchk(`DSC_OFF_SKIP_IN, 32'h0000_0000);
      rdchk(`DSC_OFF_RISE_CAP, 32'h0000_1388);
      rdchk(`DSC_OFF_FALL_CAP, 32'h0000_1388);
      rdchk(`DSC_OFF_MOT_CAP, 32'h0000_05DC);
      rdchk(`DSC_OFF_BRK_CAP, 32'h0000_05DC);
      rdchk(bw(0), 32'h0000_0000);
      rdchk(bw(3) + `DSC_BAND_CENTRE, 32'h0000_0000);
      apb(1'b0, 8'h30, 32'h0000_0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      $display("test reset done");
   endtask : t_reset

   task automatic t_skip;
      int hin [8] = '{70, 90, 100, 110, -90, -110, 190, 30};
      int hout[8] = '{70, 80, 80, 120, -80, -120, 180, 30};
      wr(`DSC_OFF_CTRL, 32'h0000_0000);
      wr(bw(0), 32'h0000_0028);
      wr(bw(0) + `DSC_BAND_CENTRE, 32'h0000_0064);
      wr(bw(1), 32'h0000_0000);
      wr(bw(1) + `DSC_BAND_CENTRE, 32'h0000_00C8);
      wr(bw(2), 32'h0000_0064);
      wr(bw(2) + `DSC_BAND_CENTRE, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
      begin
         setin(hin[i]);
         `CHK(sp, 16'(hout[i]))
         rdchk(`DSC_OFF_OUT_HZ, hout[i]);
         rdchk(`DSC_OFF_IN_HZ, hin[i]);
         rdchk(`DSC_OFF_OUT_PCT, hout[i] * 20);
      end
      wr(bw(3) + `DSC_BAND_CENTRE, 32'h0000_1770);
      rdchk(bw(3) + `DSC_BAND_CENTRE, 32'h0000_1388);
      wr(`DSC_OFF_SKIP_IN, 32'h0000_7FFF);
      rdchk(`DSC_OFF_SKIP_IN, 32'h0000_7530);
      $display("test skip done");
   endtask : t_skip

   task automatic t_rate;
      logic signed [15:0] v;
      setin(0);
      wr(`DSC_OFF_RISE_CAP, 32'h0000_2EE0);
      wr(`DSC_OFF_FALL_CAP, 32'h0000_000A);
      wr(`DSC_OFF_CTRL, 32'h0000_0001);
      setin(150);
      // 105 ticks of 100 cycles at 1200 Hz/s reach 0.5 Hz
      repeat (10492) @(posedge clk);
      `CHK(sp >= 4 && sp <= 5, 1'b1)
      fork
         dsc_far_model_inst.hold_for(3000);
      join_none
      repeat (5) @(posedge clk);
      v = sp;
      repeat (2900) @(posedge clk);
      `CHK(sp, v)
      repeat (3100) @(posedge clk);
      `CHK(sp > v, 1'b1)
      // enable low must freeze the ramp, ticks included
      ce <= 1'b0;
      @(posedge clk);
      v = sp;
      repeat (3000) @(posedge clk);
      `CHK(sp, v)
      ce <= 1'b1;
      setin(0);
      v = sp;
      repeat (6000) @(posedge clk);
      `CHK(sp >= v - 1, 1'b1)
      wr(`DSC_OFF_FALL_CAP, 32'h0000_2EE0);
      repeat (6000) @(posedge clk);
      `CHK(sp < v - 1, 1'b1)
      wr(`DSC_OFF_RISE_CAP, 32'h0000_0000);
      rdchk(`DSC_OFF_RISE_CAP, 32'h0000_000A);
      $display("test rate done");
   endtask : t_rate

   task automatic t_slip;
      wr(`DSC_OFF_CTRL, 32'h0000_0000);
      setin(0);
      dsc_far_model_inst.load(1'b0, 16'sh07D0);
      repeat (8) @(posedge clk);
      `CHK(trim, 16'h0000)
      wr(`DSC_OFF_CTRL, 32'h0000_0002);
      repeat (8) @(posedge clk);
      `CHK(trim, 16'h05DC)
      `CHK(dem, 16'h0032)
      wr(`DSC_OFF_BRK_CAP, 32'h0000_0258);
      dsc_far_model_inst.load(1'b1, -16'sh07D0);
      repeat (8) @(posedge clk);
      `CHK(trim, 16'hFDA8)
      `CHK(dem, 16'hFFEC)
      dsc_far_model_inst.load(1'b1, 16'sh012C);
      repeat (8) @(posedge clk);
      `CHK(trim, 16'h012C)
      wr(`DSC_OFF_MOT_CAP, 32'h0000_1B58);
      rdchk(`DSC_OFF_MOT_CAP, 32'h0000_1770);
      $display("test slip done");
   endtask : t_slip

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   // whole sequence needs some 32000 cycles
   initial
   begin
      #(40 * 90000);
      fail_count++;
      $display("Error t=%0t watchdog %h %h", $time, sp, trim);
      end_sim;
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_skip;
      t_rate;
      t_slip;
      end_sim;
   end
endmodule : test_dsc_top
`default_nettype wire
